// file: logic/pslm_pkg.sv
// Package with constants and types for the strap latch and MII pin block
package pslm_pkg;
  // Shared strap pins, one bit each except the four-bit rxd
  typedef struct packed {
    logic [3:0] rxd;
    logic rxdv;
    logic crs;
    logic rxc;
    logic rxer;
    logic intrp;
  } pslm_pins_t;

  // Captured configuration
  typedef struct packed {
    logic [4:0] mgmt_addr;
    logic [2:0] op_mode;
    logic mdix_en;
    logic b2b_mode;
    logic mode_reserved;
    logic ctrl0_an_disable;
    logic nand_tree_en;
    logic filter_disable;
  } pslm_cfg_t;

  // Internal pull direction per pin, 1 = pull-up
  localparam pslm_pins_t PULL_UP_MAP = '{rxd: 4'h9, rxdv: 1'h0, crs: 1'h0, rxc: 1'h0, rxer: 1'h0, intrp: 1'h1};
  localparam logic [1:0] ADDR_UPPER = 2'h0;
  localparam logic [2:0] MODE_MII_NOMDIX = 3'h0;
  localparam logic [2:0] MODE_MII_MDIX = 3'h2;
  localparam logic [2:0] MODE_B2B_MDIX = 3'h6;
  localparam int CTRL0_AN_BIT = 12;
  localparam pslm_cfg_t CFG_RESET = '{mgmt_addr: 5'h01, op_mode: 3'h0, mdix_en: 1'h0, b2b_mode: 1'h0,
                                      mode_reserved: 1'h0, ctrl0_an_disable: 1'h1, nand_tree_en: 1'h0,
                                      filter_disable: 1'h0};
  // MII clock: 100 MHz core over 25 MHz nibble rate
  localparam int CORE_CLK_MHZ = 100;
  localparam int MII_CLK_MHZ = 25;
  localparam int MII_DIV = CORE_CLK_MHZ / MII_CLK_MHZ;
  localparam logic [1:0] PH_RISE = 2'h0;
  localparam logic [1:0] PH_FALL = 2'h2;
  localparam logic [1:0] PH_TX_SAMPLE = 2'h3;
  localparam logic [1:0] PH_LAST = 2'(MII_DIV - 1);

  typedef enum logic {PSLM_ST_RESET, PSLM_ST_RUN} pslm_state_t;
endpackage

// file: logic/pslm_top.sv
// Strap capture at reset release and MII pin control
`timescale 1ns/1ps
`default_nettype none
module pslm_top (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire pslm_pkg::pslm_pins_t STRAP_I,
  output pslm_pkg::pslm_pins_t STRAP_O,
  output pslm_pkg::pslm_pins_t STRAP_OE,
  output pslm_pkg::pslm_pins_t PULL_UP_EN,
  output pslm_pkg::pslm_pins_t PULL_DN_EN,
  output logic TXC,
  input wire logic TXEN,
  input wire logic [3:0] TXD,
  input wire logic [3:0] RX_DATA,
  input wire logic RX_VALID,
  input wire logic RX_ERR,
  input wire logic RX_CRS,
  input wire logic IRQ_REQ,
  output logic RX_TAKE,
  output logic [3:0] TX_DATA,
  output logic TX_VALID,
  output pslm_pkg::pslm_cfg_t CFG,
  output logic CFG_VALID
);
  pslm_pkg::pslm_pins_t strap_s1_ff, strap_s2_ff;
  logic txen_s1_ff, txen_s2_ff;
  logic [3:0] txd_s1_ff, txd_s2_ff;
  pslm_pkg::pslm_state_t state_ff, nxt_state;
  pslm_pkg::pslm_cfg_t cfg_ff, nxt_cfg;
  logic cfg_valid_ff, nxt_cfg_valid;
  pslm_pkg::pslm_pins_t o_ff, nxt_o, oe_ff, nxt_oe, pu_ff, nxt_pu, pd_ff, nxt_pd;
  logic [1:0] div_ff, nxt_div;
  logic mii_clk_ff, nxt_mii_clk;
  logic take_ff, nxt_take;
  logic [3:0] txdata_ff, nxt_txdata;
  logic txvalid_ff, nxt_txvalid;

  function automatic pslm_pkg::pslm_cfg_t decode_straps(input pslm_pkg::pslm_pins_t s);
    pslm_pkg::pslm_cfg_t c;
    c = pslm_pkg::CFG_RESET;
    c.mgmt_addr = {pslm_pkg::ADDR_UPPER, s.rxd[1], s.rxd[2], s.rxd[3]};
    c.op_mode = {s.rxdv, s.crs, s.rxc};
    c.mdix_en = (c.op_mode == pslm_pkg::MODE_MII_MDIX) || (c.op_mode == pslm_pkg::MODE_B2B_MDIX);
    c.b2b_mode = (c.op_mode == pslm_pkg::MODE_B2B_MDIX);
    c.mode_reserved = !(c.op_mode == pslm_pkg::MODE_MII_NOMDIX || c.mdix_en);
    c.ctrl0_an_disable = s.rxd[0];
    c.nand_tree_en = !s.intrp;
    c.filter_disable = s.rxer;
    return c;
  endfunction

  // Pin synchronisers, no reset
  always_ff @(posedge CORE_CLK) begin
    strap_s1_ff <= STRAP_I;
    strap_s2_ff <= strap_s1_ff;
    txen_s1_ff <= TXEN;
    txen_s2_ff <= txen_s1_ff;
    txd_s1_ff <= TXD;
    txd_s2_ff <= txd_s1_ff;
  end

  // Capture state and pin direction
  always_comb begin
    nxt_state = state_ff;
    nxt_cfg = cfg_ff;
    nxt_cfg_valid = cfg_valid_ff;
    nxt_pu = '0;
    nxt_pd = '0;
    nxt_oe = oe_ff;
    case (state_ff)
      pslm_pkg::PSLM_ST_RESET: begin
        nxt_cfg = decode_straps(strap_s2_ff);
        nxt_cfg_valid = 1'b1;
        nxt_oe = '1;
        nxt_oe.intrp = IRQ_REQ;
        nxt_state = pslm_pkg::PSLM_ST_RUN;
      end
      default: begin
        nxt_oe.intrp = IRQ_REQ;
      end
    endcase
    if (!NRST) begin
      nxt_state = pslm_pkg::PSLM_ST_RESET;
      nxt_cfg = pslm_pkg::CFG_RESET;
      nxt_cfg_valid = 1'b0;
      nxt_oe = '0;
      nxt_pu = pslm_pkg::PULL_UP_MAP;
      nxt_pd = ~pslm_pkg::PULL_UP_MAP;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    state_ff <= nxt_state;
    cfg_ff <= nxt_cfg;
    cfg_valid_ff <= nxt_cfg_valid;
    oe_ff <= nxt_oe;
    pu_ff <= nxt_pu;
    pd_ff <= nxt_pd;
  end

  // MII clocks and data paths
  always_comb begin
    nxt_div = (div_ff == pslm_pkg::PH_LAST) ? 2'h0 : div_ff + 2'h1;
    nxt_mii_clk = mii_clk_ff;
    nxt_o = o_ff;
    nxt_take = 1'b0;
    nxt_txdata = txdata_ff;
    nxt_txvalid = 1'b0;
    if (div_ff == pslm_pkg::PH_RISE) begin
      nxt_mii_clk = 1'b1;
    end else if (div_ff == pslm_pkg::PH_FALL) begin
      nxt_mii_clk = 1'b0;
      nxt_o.rxdv = RX_VALID;
      nxt_o.rxd = RX_VALID ? RX_DATA : 4'h0;
      nxt_o.rxer = RX_VALID & RX_ERR;
      nxt_o.crs = RX_CRS;
      nxt_take = RX_VALID;
    end else if (div_ff == pslm_pkg::PH_TX_SAMPLE && txen_s2_ff) begin
      nxt_txdata = txd_s2_ff;
      nxt_txvalid = 1'b1;
    end
    nxt_o.rxc = nxt_mii_clk;
    nxt_o.intrp = 1'b0;
    if (!NRST || state_ff == pslm_pkg::PSLM_ST_RESET) begin
      nxt_div = 2'h0;
      nxt_mii_clk = 1'b0;
      nxt_o = '0;
      nxt_take = 1'b0;
      nxt_txdata = 4'h0;
      nxt_txvalid = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    div_ff <= nxt_div;
    mii_clk_ff <= nxt_mii_clk;
    o_ff <= nxt_o;
    take_ff <= nxt_take;
    txdata_ff <= nxt_txdata;
    txvalid_ff <= nxt_txvalid;
  end

  assign STRAP_O = o_ff;
  assign STRAP_OE = oe_ff;
  assign PULL_UP_EN = pu_ff;
  assign PULL_DN_EN = pd_ff;
  assign TXC = mii_clk_ff;
  assign RX_TAKE = take_ff;
  assign TX_DATA = txdata_ff;
  assign TX_VALID = txvalid_ff;
  assign CFG = cfg_ff;
  assign CFG_VALID = cfg_valid_ff;

  a_pins_released: assert property (@(posedge CORE_CLK) $past(NRST) && !NRST |=> STRAP_OE.rxd == 4'h0 && PULL_UP_EN.rxd == 4'h9)
    else $error("Strap pins driven or unpulled in reset");
  a_pins_driven: assert property (@(posedge CORE_CLK) disable iff (!NRST) $rose(CFG_VALID) |-> STRAP_OE.rxd == 4'hF && STRAP_OE.rxc && PULL_DN_EN == '0)
    else $error("Strap pins not driven after capture");
  a_rx_step_clock: assert property (@(posedge CORE_CLK) disable iff (!NRST) $changed(STRAP_O.rxd) && CFG_VALID |-> $fell(STRAP_O.rxc))
    else $error("Receive data changed off the clock fall");
  a_rx_idle_zero: assert property (@(posedge CORE_CLK) disable iff (!NRST) !STRAP_O.rxdv |-> STRAP_O.rxd == 4'h0)
    else $error("Receive data shown without valid");
  a_tx_enable_only: assert property (@(posedge CORE_CLK) disable iff (!NRST) TX_VALID |-> $past(txen_s2_ff) && TX_DATA == $past(txd_s2_ff))
    else $error("Transmit nibble taken without enable");
  a_capture_release: assert property (@(posedge CORE_CLK) !$past(NRST) ##1 NRST ##1 NRST |-> CFG_VALID && CFG.ctrl0_an_disable == $past(strap_s2_ff.rxd[0], 2))
    else $error("Straps not captured at release");
  a_addr_upper_zero: assert property (@(posedge CORE_CLK) disable iff (!NRST) CFG.mgmt_addr[4:3] == 2'h0)
    else $error("Upper address bits not zero");
  a_mode_decode: assert property (@(posedge CORE_CLK) disable iff (!NRST) CFG_VALID |-> CFG.b2b_mode == (CFG.op_mode == 3'h6) && CFG.mdix_en == (CFG.op_mode == 3'h2 || CFG.op_mode == 3'h6))
    else $error("Operating mode decode wrong");
  a_cfg_held: assert property (@(posedge CORE_CLK) disable iff (!NRST) CFG_VALID && $past(CFG_VALID) |-> $stable(CFG))
    else $error("Configuration changed after capture");
  a_filter_nand: assert property (@(posedge CORE_CLK) disable iff (!NRST) $rose(CFG_VALID) |-> CFG.filter_disable == $past(strap_s2_ff.rxer) && CFG.nand_tree_en == !$past(strap_s2_ff.intrp))
    else $error("Filter or test strap captured wrongly");
  // Pulls, enables and configuration while reset is low; interrupt pin level
  a_pulls_in_reset: assert property (@(posedge CORE_CLK)
    !NRST |=> PULL_UP_EN == pslm_pkg::PULL_UP_MAP && PULL_DN_EN == ~pslm_pkg::PULL_UP_MAP && STRAP_OE == '0)
    else $error("Pulls or enables wrong in reset");
  a_cfg_in_reset: assert property (@(posedge CORE_CLK)
    !NRST |=> CFG == pslm_pkg::CFG_RESET && !CFG_VALID)
    else $error("Configuration not at default in reset");
  a_intrp_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    STRAP_O.intrp == 1'b0)
    else $error("Interrupt pin driven high");
  // Receive path
  a_take_pulse: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    RX_TAKE |-> STRAP_O.rxdv ##1 !RX_TAKE)
    else $error("Receive take not a single valid pulse");
  a_rxer_valid: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    STRAP_O.rxer |-> STRAP_O.rxdv)
    else $error("Receive error shown without valid");
  // Transmit path
  a_txc_period: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $rose(TXC) |-> ##4 $rose(TXC))
    else $error("Transmit clock period wrong");
  a_tx_idle: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    !$past(txen_s2_ff) |-> !TX_VALID)
    else $error("Transmit nibble taken while idle");
  // Captured fields
  a_addr_capture: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $rose(CFG_VALID) |-> CFG.mgmt_addr[2:0] == {$past(strap_s2_ff.rxd[1]), $past(strap_s2_ff.rxd[2]), $past(strap_s2_ff.rxd[3])})
    else $error("Address straps captured wrongly");
  a_mode_capture: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    $rose(CFG_VALID) |-> CFG.op_mode == {$past(strap_s2_ff.rxdv), $past(strap_s2_ff.crs), $past(strap_s2_ff.rxc)})
    else $error("Mode straps captured wrongly");
  a_mode_flag: assert property (@(posedge CORE_CLK) disable iff (!NRST)
    CFG_VALID |-> CFG.mode_reserved == !(CFG.op_mode == 3'h0 || CFG.op_mode == 3'h2 || CFG.op_mode == 3'h6))
    else $error("Reserved mode flag wrong");
endmodule
`default_nettype wire

// file: verif/pslm_mac_model.sv
// MAC and board model for the shared strap pads and the transmit pins
`timescale 1ns/1ps
`default_nettype none
module pslm_mac_model (
  input wire logic txc,
  input wire pslm_pkg::pslm_pins_t strap_o,
  input wire pslm_pkg::pslm_pins_t strap_oe,
  input wire pslm_pkg::pslm_pins_t pull_up_en,
  input wire pslm_pkg::pslm_pins_t pull_dn_en,
  input wire logic board_en,
  input wire pslm_pkg::pslm_pins_t board_lvl,
  input wire logic tx_go,
  input wire logic [3:0] tx_nib,
  output pslm_pkg::pslm_pins_t pad,
  output logic txen,
  output logic [3:0] txd
);
  // Device drive wins, else board resistors, else pulls
  always_comb begin
    pad = board_en ? board_lvl : pslm_pkg::pslm_pins_t'((pull_up_en | 9'h001) & ~pull_dn_en);
    pad = pslm_pkg::pslm_pins_t'((pad & ~strap_oe) | (strap_o & strap_oe));
  end
  initial begin
    txen = 1'b0;
    txd = 4'h0;
  end
  // Nibble changes after the transmit clock rises
  always @(posedge txc) begin
    txen <= tx_go;
    txd <= tx_go ? tx_nib : ~txd;
  end
endmodule
`default_nettype wire

// file: verif/pslm_top_tb.sv
// Self-checking bench for the strap latch and MII pins
`timescale 1ns/1ps
`default_nettype none
module pslm_top_tb;
  typedef struct packed {logic en; pslm_pkg::pslm_pins_t lvl; pslm_pkg::pslm_cfg_t cfg;} pslm_row_t;
  // Rows keep to the allowed mode codes
  localparam pslm_row_t ROWS [4] = '{'{1'h0, 9'h121, 14'h0204}, '{1'h1, 9'h0CA, 14'h0CA3},
                                     '{1'h1, 9'h1F9, 14'h0FB4}, '{1'h1, 9'h000, 14'h0002}};
  logic clk = 1'b0, nrst = 1'b0, board_en = 1'b0, tx_go = 1'b0, irq = 1'b0, rx_valid = 1'b0;
  logic rx_err = 1'b0, rx_crs = 1'b0;
  logic txen, txc, rx_take, tx_valid, cfg_valid;
  logic [3:0] txd, tx_data, tx_nib = 4'h5, rx_data = 4'h0;
  pslm_pkg::pslm_pins_t pad, s_o, s_oe, pu, pd, board_lvl = 9'h000;
  pslm_pkg::pslm_cfg_t cfg;
  int bad_count = 0, checks = 0, cyc = 0;
  always #5 clk = ~clk;
  pslm_top u_pslm_top (.CORE_CLK(clk), .NRST(nrst), .STRAP_I(pad), .STRAP_O(s_o), .STRAP_OE(s_oe),
    .PULL_UP_EN(pu), .PULL_DN_EN(pd), .TXC(txc), .TXEN(txen), .TXD(txd), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .RX_ERR(rx_err), .RX_CRS(rx_crs), .IRQ_REQ(irq), .RX_TAKE(rx_take),
    .TX_DATA(tx_data), .TX_VALID(tx_valid), .CFG(cfg), .CFG_VALID(cfg_valid));
  pslm_mac_model u_pslm_mac_model (.txc(txc), .strap_o(s_o), .strap_oe(s_oe), .pull_up_en(pu),
    .pull_dn_en(pd), .board_en(board_en), .board_lvl(board_lvl), .tx_go(tx_go), .tx_nib(tx_nib),
    .pad(pad), .txen(txen), .txd(txd));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_hi(input bit tx);
    for (int i = 0; i < 20 && !(tx ? tx_valid === 1'b1 : rx_take === 1'b1); i++) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    foreach (ROWS[i]) begin
      @(negedge clk);
      nrst = 1'b0;
      board_en = ROWS[i].en;
      board_lvl = ROWS[i].lvl;
      repeat (4) @(negedge clk);
      check("oe in reset", 16'h0000, 16'(s_oe));
      check("pull-up in reset", 16'(pslm_pkg::PULL_UP_MAP), 16'(pu));
      check("valid in reset", 16'h0000, 16'(cfg_valid));
      nrst = 1'b1;
      @(negedge clk);
      check("cfg", 16'(ROWS[i].cfg), 16'(cfg));
      check("valid", 16'h0001, 16'(cfg_valid));
      check("oe after", 16'h01FE, 16'(s_oe));
      check("pulls off", 16'h0000, 16'(pu | pd));
      board_lvl = ~ROWS[i].lvl;
      repeat (6) @(negedge clk);
      check("cfg held", 16'(ROWS[i].cfg), 16'(cfg));
      $display("Strap row %0d done", i);
    end
    rx_data = 4'hA;
    rx_valid = 1'b1;
    rx_err = 1'b1;
    rx_crs = 1'b1;
    wait_hi(1'b0);
    check("rx take", 16'h0001, 16'(rx_take));
    check("rx pins", 16'h0153, 16'({s_o.rxd, s_o.rxdv, s_o.rxc, txc, s_o.rxer, s_o.crs}));
    rx_valid = 1'b0;
    rx_crs = 1'b0;
    @(negedge clk);
    wait_hi(1'b0);
    check("rx idle", 16'h0000, 16'({s_o.rxd, s_o.rxdv, s_o.rxer, s_o.crs}));
    $display("Receive test done");
    tx_go = 1'b1;
    wait_hi(1'b1);
    check("tx nibble", 16'h000B, 16'({tx_data, tx_valid}));
    tx_go = 1'b0;
    repeat (8) @(negedge clk);
    wait_hi(1'b1);
    check("tx idle", 16'h0000, 16'(tx_valid));
    $display("Transmit test done");
    irq = 1'b1;
    repeat (2) @(negedge clk);
    check("irq pin", 16'h0002, 16'({s_oe.intrp, s_o.intrp}));
    $display("Interrupt pin test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
